// ===== rtl/lai_pkg.sv
// Package: constants for the literal ALU execute slice
package lai_pkg;
    localparam int unsigned OSC_PER_CYCLE    = 4;
    localparam logic [1:0]  PHASE_LAST       = 2'(OSC_PER_CYCLE - 1);
    localparam logic [5:0]  OPC_ADD_LIT_MASK = 6'h3e;
    localparam logic [5:0]  OPC_ADD_LIT      = 6'h3e;
    localparam logic [5:0]  OPC_AND_LIT      = 6'h39;
    localparam logic [5:0]  OPC_MOVE_FILE    = 6'h08;
    localparam logic [5:0]  OPC_GOTO_MASK    = 6'h30;
    localparam logic [5:0]  OPC_GOTO_CALL    = 6'h20;
    localparam int unsigned DEST_BIT         = 7;
    localparam logic [6:0]  ADDR_TIMER_ZERO  = 7'h01;
    localparam logic [6:0]  ADDR_SECOND_IO   = 7'h06;
    localparam logic [7:0]  ACC_RESET        = 8'h00;
    localparam logic [12:0] IAC_RESET        = 13'h0000;

    typedef enum logic [1:0] {LAI_EXEC, LAI_IDLE} lai_state_e;

    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       nibble_carry;
        logic       zero;
    } lai_alu_s;
endpackage

// ===== rtl/lai_alu.sv
// Combinational 8-bit add/and unit with flag outputs
module lai_alu
    import lai_pkg::*;
(
    input  wire logic [7:0] i_a,
    input  wire logic [7:0] i_b,
    input  wire logic       i_sel_and,
    output logic      [7:0] o_result,
    output logic            o_carry,
    output logic            o_nibble_carry,
    output logic            o_zero
);
    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb
    begin
        sum            = {1'b0, i_a} + {1'b0, i_b};
        low_sum        = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
        o_result       = i_sel_and ? (i_a & i_b) : sum[7:0];
        o_carry        = sum[8];
        o_nibble_carry = low_sum[4];
        o_zero         = (o_result == 8'h00);
    end
endmodule

// ===== rtl/lai_core.sv
// Execute slice: literal add/and, file move, timer-zero and two-cycle handling
// Overview of operation
// - Read-modify-write of an I/O port sources the sensed pin levels; here only the port at ADDR_SECOND_IO does.
// - Writing timer-zero count clears prescaler when assigned to timer zero.
// - Counter-changing or skip-taken instructions take two cycles, second idle.
// - Add-literal adds low byte to accumulator, updates carry, nibble carry, zero.
// - And-literal ANDs low byte with accumulator, updates zero only.
// - Destination bit zero writes accumulator, one writes file register.
// - Each instruction cycle spans four oscillator periods.
module lai_core
    import lai_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic [13:0] i_instr,
    input  wire logic        i_skip_taken,
    input  wire logic [7:0]  i_port_pins,
    input  wire logic [7:0]  i_file_rdata,
    input  wire logic        i_prescaler_to_timer,
    output logic      [7:0]  o_accumulator,
    output logic             o_carry_flag,
    output logic             o_nibble_carry_flag,
    output logic             o_zero_flag,
    output logic      [12:0] o_instruction_address_counter,
    output logic             o_fetch,
    output logic             o_idle_cycle,
    output logic      [6:0]  o_file_addr,
    output logic      [7:0]  o_file_wdata,
    output logic             o_file_we,
    output logic             o_prescaler_clear
);
    logic [7:0]  pins_meta;
    logic [7:0]  pins_sync;
    logic [1:0]  phase;
    lai_state_e  state;
    logic [7:0]  acc;
    logic        c_flag;
    logic        nc_flag;
    logic        z_flag;
    logic [12:0] iac;
    logic        fetch;
    logic        idle_q;
    logic        jump_q;
    logic [6:0]  faddr;
    logic [7:0]  fwdata;
    logic        fwe;
    logic        psc_clr;

    logic [1:0]  next_phase;
    lai_state_e  next_state;
    logic [7:0]  next_acc;
    logic        next_c_flag;
    logic        next_nc_flag;
    logic        next_z_flag;
    logic [12:0] next_iac;
    logic        next_fetch;
    logic        next_idle_q;
    logic        next_jump_q;
    logic [6:0]  next_faddr;
    logic [7:0]  next_fwdata;
    logic        next_fwe;
    logic        next_psc_clr;

    logic [5:0]  opc;
    logic [7:0]  literal;
    logic [6:0]  fsel;
    logic        dest;
    logic [7:0]  alu_b;
    logic        alu_and;
    logic [7:0]  alu_res;
    logic        alu_c;
    logic        alu_nc;
    logic        alu_z;

    assign opc     = i_instr[13:8];
    assign literal = i_instr[7:0];
    assign fsel    = i_instr[6:0];
    assign dest    = i_instr[DEST_BIT];
    assign alu_and = (opc == OPC_AND_LIT);

    // Pins are asynchronous to the core clock
    always_ff @(posedge i_ref_clk)
    begin
        pins_meta <= i_port_pins;
        pins_sync <= pins_meta;
    end

    always_comb
    begin
        // Port reads take pin levels, not the output latch
        if (fsel == ADDR_SECOND_IO)
            alu_b = pins_sync;
        else
            alu_b = i_file_rdata;
    end

    lai_alu u_alu (
        .i_a            (acc),
        .i_b            (literal),
        .i_sel_and      (alu_and),
        .o_result       (alu_res),
        .o_carry        (alu_c),
        .o_nibble_carry (alu_nc),
        .o_zero         (alu_z)
    );

    always_comb
    begin
        next_phase   = (phase == PHASE_LAST) ? 2'h0 : phase + 2'h1;
        next_state   = state;
        next_acc     = acc;
        next_c_flag  = c_flag;
        next_nc_flag = nc_flag;
        next_z_flag  = z_flag;
        next_iac     = iac;
        next_fetch   = 1'b0;
        next_idle_q  = idle_q;
        next_jump_q  = jump_q;
        next_faddr   = fsel;
        next_fwdata  = fwdata;
        next_fwe     = 1'b0;
        next_psc_clr = 1'b0;
        if (phase == PHASE_LAST)
        begin
            next_fetch  = 1'b1;
            next_idle_q = 1'b0;
            next_iac    = iac + 13'h0001;
            unique case (state)
                LAI_EXEC:
                begin
                    if ((opc & OPC_ADD_LIT_MASK) == OPC_ADD_LIT)
                    begin
                        next_acc     = alu_res;
                        next_c_flag  = alu_c;
                        next_nc_flag = alu_nc;
                        next_z_flag  = alu_z;
                    end
                    else if (alu_and)
                    begin
                        next_acc    = alu_res;
                        next_z_flag = alu_z;
                    end
                    else if (opc == OPC_MOVE_FILE)
                    begin
                        next_z_flag = (alu_b == 8'h00);
                        if (dest)
                        begin
                            next_fwdata = alu_b;
                            next_fwe    = 1'b1;
                            // Only a real write to the counter resets the prescaler
                            next_psc_clr = (fsel == ADDR_TIMER_ZERO)
                                           && i_prescaler_to_timer;
                        end
                        else
                        begin
                            next_acc = alu_b;
                        end
                    end
                    if ((opc & OPC_GOTO_MASK) == OPC_GOTO_CALL)
                    begin
                        next_iac    = i_instr[12:0];
                        next_state  = LAI_IDLE;
                        next_idle_q = 1'b1;
                        next_jump_q = 1'b1;
                    end
                    else if (i_skip_taken)
                    begin
                        next_state  = LAI_IDLE;
                        next_idle_q = 1'b1;
                    end
                end
                LAI_IDLE:
                begin
                    // Word shown now is ignored; a jump target is held so it runs next
                    if (jump_q)
                        next_iac = iac;
                    next_jump_q = 1'b0;
                    next_state  = LAI_EXEC;
                end
                default:
                begin
                    next_state = LAI_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            phase   <= 2'h0;
            state   <= LAI_EXEC;
            acc     <= ACC_RESET;
            c_flag  <= 1'b0;
            nc_flag <= 1'b0;
            z_flag  <= 1'b0;
            iac     <= IAC_RESET;
            fetch   <= 1'b0;
            idle_q  <= 1'b0;
            jump_q  <= 1'b0;
            faddr   <= 7'h00;
            fwdata  <= 8'h00;
            fwe     <= 1'b0;
            psc_clr <= 1'b0;
        end
        else
        begin
            phase   <= next_phase;
            state   <= next_state;
            acc     <= next_acc;
            c_flag  <= next_c_flag;
            nc_flag <= next_nc_flag;
            z_flag  <= next_z_flag;
            iac     <= next_iac;
            fetch   <= next_fetch;
            idle_q  <= next_idle_q;
            jump_q  <= next_jump_q;
            faddr   <= next_faddr;
            fwdata  <= next_fwdata;
            fwe     <= next_fwe;
            psc_clr <= next_psc_clr;
        end
    end

    assign o_accumulator                 = acc;
    assign o_carry_flag                  = c_flag;
    assign o_nibble_carry_flag           = nc_flag;
    assign o_zero_flag                   = z_flag;
    assign o_instruction_address_counter = iac;
    assign o_fetch                       = fetch;
    assign o_idle_cycle                  = idle_q;
    assign o_file_addr                   = faddr;
    assign o_file_wdata                  = fwdata;
    assign o_file_we                     = fwe;
    assign o_prescaler_clear             = psc_clr;
endmodule

// ===== testbench/lai_core_properties.sv
// Checker: concurrent properties of the literal execute slice
module lai_core_chk
    import lai_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_reset,
    input wire logic [13:0] i_instr,
    input wire logic        i_skip_taken,
    input wire logic [7:0]  i_port_pins,
    input wire logic        i_prescaler_to_timer,
    input wire logic [7:0]  o_accumulator,
    input wire logic        o_carry_flag,
    input wire logic        o_nibble_carry_flag,
    input wire logic        o_zero_flag,
    input wire logic [12:0] o_instruction_address_counter,
    input wire logic        o_fetch,
    input wire logic        o_idle_cycle,
    input wire logic [7:0]  o_file_wdata,
    input wire logic        o_file_we,
    input wire logic        o_prescaler_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph, next_ph;
    // Own phase count, so a stuck core phase cannot mask itself
    always_comb next_ph = i_reset ? 2'h0 : ph + 2'h1;
    always_ff @(posedge i_ref_clk) ph <= next_ph;
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);
    wire       ex = ph == 2'h3 && !o_idle_cycle;
    wire [5:0] op = i_instr[13:8];
    wire       mv = ex && op == OPC_MOVE_FILE;
    wire       add_ex = ex && (op & OPC_ADD_LIT_MASK) == OPC_ADD_LIT;
    wire       and_ex = ex && op == OPC_AND_LIT;
    wire [8:0] sum = 9'(o_accumulator) + 9'(i_instr[7:0]);
    wire [7:0] andv = o_accumulator & i_instr[7:0];
    wire [4:0] nib = 5'(o_accumulator[3:0]) + 5'(i_instr[3:0]);
    wire       jmp_ex = ex && (op & OPC_GOTO_MASK) == OPC_GOTO_CALL;
    sequence s_jump;
        o_instruction_address_counter[10:0] == $past(i_instr[10:0]);
    endsequence
    sequence s_idle4;
        o_idle_cycle [*4];
    endsequence
    fetch_phase_a: assert property (o_fetch |-> ph == 2'h0)
        else $error("fetch off phase");
    add_sum_a: assert property (add_ex |=> {o_carry_flag, o_accumulator} == $past(sum))
        else $error("add sum wrong");
    zero_flag_a: assert property (add_ex || and_ex |=> o_zero_flag == !(|o_accumulator))
        else $error("zero flag wrong");
    and_res_a: assert property (and_ex |=> o_accumulator == $past(andv) && $stable(o_carry_flag))
        else $error("and result wrong");
    idle_hold_a: assert property (ph == 2'h3 && o_idle_cycle |=>
        $stable(o_accumulator) && !o_file_we) else $error("idle cycle not idle");
    jump_idle_a: assert property (ex && (op & OPC_GOTO_MASK) == OPC_GOTO_CALL |=>
        s_jump ##[0:3] o_idle_cycle [*4]) else $error("jump without idle cycle");
    pin_src_a: assert property (mv && i_instr[6:0] == ADDR_SECOND_IO |=>
        // Pins reach the core through two flops, so look three edges back
        ($past(i_instr[DEST_BIT]) ? o_file_we && o_file_wdata == $past(i_port_pins, 3)
        : !o_file_we && o_accumulator == $past(i_port_pins, 3))) else $error("pin source");
    presc_clr_a: assert property (mv && i_instr[DEST_BIT] && i_prescaler_to_timer
        && i_instr[6:0] == ADDR_TIMER_ZERO |=> o_prescaler_clear ##1 !o_prescaler_clear)
        else $error("prescaler not cleared");
    presc_keep_a: assert property (mv && i_instr[DEST_BIT] && !i_prescaler_to_timer
        && i_instr[6:0] == ADDR_TIMER_ZERO |=> !o_prescaler_clear)
        else $error("prescaler cleared while unassigned");
    nib_carry_a: assert property (add_ex |=> o_nibble_carry_flag == $past(nib[4]))
        else $error("nibble carry wrong");
    skip_idle_a: assert property (ex && i_skip_taken |=> s_idle4)
        else $error("skip without idle cycle");
    jump_hold_a: assert property (jmp_ex |-> ##5
        o_instruction_address_counter[10:0] == $past(i_instr[10:0], 5))
        else $error("jump target lost");
endmodule

// ===== testbench/lai_prog_rom.sv
// Program memory model: fixed program, read by the instruction counter
module lai_prog_rom
(
    input  wire logic [12:0] i_addr,
    output logic      [13:0] o_instr
);
    timeunit 1ns;
    timeprecision 1ps;
    // Word 11 is skipped, so its add must never land in the accumulator
    logic [13:0] rom [16] = '{14'h3e10, 14'h3f15, 14'h3eff, 14'h39db, 14'h3e08, 14'h3ef8,
        14'h0886, 14'h0806, 14'h0881, 14'h280a, 14'h3e01, 14'h3e40, 14'h3e02, 14'h0881,
        14'h0, 14'h0};
    assign o_instr = rom[i_addr[3:0]];
endmodule

// ===== testbench/tb.sv
// Testbench: runs a short program and checks results per cycle
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk = 0, i_reset = 1, i_skip_taken = 0, i_prescaler_to_timer = 1;
    logic [7:0]  i_port_pins = 8'ha5, i_file_rdata = 8'h3c, o_accumulator, o_file_wdata;
    logic [13:0] i_instr;
    logic [12:0] o_instruction_address_counter;
    logic [6:0]  o_file_addr;
    logic        o_carry_flag, o_nibble_carry_flag, o_zero_flag, o_fetch, o_idle_cycle;
    logic        o_file_we, o_prescaler_clear;
    int          n_mismatch = 0, cmp_count = 0;
    lai_core i_lai_core (.*);
    lai_prog_rom i_lai_prog_rom (.i_addr(o_instruction_address_counter), .o_instr(i_instr));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %h not %h", $time, seen, want);
        end
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // One instruction cycle, then let that edge's updates land
    task automatic wt();
        repeat (4) @(posedge i_ref_clk);
        #1;
    endtask
    // Same cycle, with level inputs changed just after its first edge
    task automatic wt_drv(input logic skip, input logic presc);
        @(posedge i_ref_clk);
        i_skip_taken         <= skip;
        i_prescaler_to_timer <= presc;
        repeat (3) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic step(input logic [7:0] acc, input logic [2:0] fl);
        wt();
        chk({o_carry_flag, o_nibble_carry_flag, o_zero_flag, o_accumulator}, {fl, acc});
    endtask
    initial forever #12.5 i_ref_clk = ~i_ref_clk;
    initial
    begin
        repeat (300) @(posedge i_ref_clk);
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        repeat (16) @(posedge i_ref_clk);
        i_reset <= 0;
        step(8'h10, 3'b000);
        step(8'h25, 3'b000);
        step(8'h24, 3'b110);
        step(8'h00, 3'b111);
        step(8'h08, 3'b000);
        step(8'h00, 3'b111);
        wt();
        chk({o_file_we, o_file_addr, o_file_wdata}, {1'b1, 7'h06, 8'ha5});
        wt();
        chk({o_file_we, o_accumulator}, {1'b0, 8'ha5});
        wt();
        chk(o_prescaler_clear, 1'b1);
        wt();
        chk({o_idle_cycle, o_instruction_address_counter[10:0]}, {1'b1, 11'h00a});
        wt();
        chk(o_accumulator, 8'ha5);
        chk({o_idle_cycle, o_instruction_address_counter[10:0]}, {1'b0, 11'h00a});
        wt_drv(1'b1, 1'b1);
        chk(o_accumulator, 8'ha6);
        chk(o_idle_cycle, 1'b1);
        wt_drv(1'b0, 1'b1);
        chk({o_accumulator, o_instruction_address_counter[10:0]}, {8'ha6, 11'h00c});
        wt_drv(1'b0, 1'b0);
        chk({o_carry_flag, o_nibble_carry_flag, o_zero_flag}, 3'b000);
        chk(o_accumulator, 8'ha8);
        wt();
        chk({o_file_we, o_file_wdata, o_prescaler_clear}, {1'b1, 8'h3c, 1'b0});
        stop_test();
    end
endmodule
bind lai_core lai_core_chk i_lai_core_chk (.*);
